// file: common/timer_regs.svh
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Byte offsets on the register bus
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_COUNT 8'h08
`define OFS_CMP_A 8'h0c
`define OFS_CMP_B 8'h10
`define OFS_FLAGS 8'h14
`define OFS_MASK 8'h18

// Field positions
`define CA_WGM_LO 1:0
`define CA_COM_B 5:4
`define CA_COM_A 7:6
`define CB_CS 2:0
`define CB_WGM2 3
`define CB_FOC_B 6
`define CB_FOC_A 7
`define FL_OVF 0
`define FL_CMP_A 1
`define FL_CMP_B 2

// Reset and special values
`define RST_BYTE 8'h00
`define RST_FLAGS 3'h0
`define VAL_BOTTOM 8'h00
`define VAL_MAX 8'hff

// Clock select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_TAP0 3'h2
`define CS_TAP1 3'h3
`define CS_TAP2 3'h4
`define CS_TAP3 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// Waveform mode codes
`define WGM_NORMAL 3'h0
`define WGM_CTC 3'h2

`endif

// file: common/timer_pkg.sv
package timer_pkg;

    typedef struct packed {
        logic tick;
        logic match;
        logic force_hit;
        logic at_top;
        logic counting_down;
        logic pwm;
        logic phase_correct;
        logic reload;
    } chan_evt_type;

endpackage

// file: hdl/tick_select.sv
`include "timer_regs.svh"

module tick_select (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] clock_select_field,
    input wire logic [3:0] prescale_taps,
    input wire logic external_count_pin,
    output logic timer_tick
);
    logic pin_meta_r;
    logic pin_sync_r;
    logic pin_prev_r;
    logic pin_rise;
    logic pin_fall;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= external_count_pin;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign pin_rise = pin_sync_r & ~pin_prev_r;
    assign pin_fall = ~pin_sync_r & pin_prev_r;

    always_comb begin
        unique case (clock_select_field)
            `CS_STOP: timer_tick = 1'b0;
            `CS_DIV1: timer_tick = 1'b1;
            `CS_TAP0: timer_tick = prescale_taps[0];
            `CS_TAP1: timer_tick = prescale_taps[1];
            `CS_TAP2: timer_tick = prescale_taps[2];
            `CS_TAP3: timer_tick = prescale_taps[3];
            `CS_EXT_FALL: timer_tick = pin_fall;
            `CS_EXT_RISE: timer_tick = pin_rise;
        endcase
    end

    chk_stop_no_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
        clock_select_field == `CS_STOP |-> !timer_tick)
        else $error("tick delivered while stopped");
    chk_ext_rise_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
        clock_select_field == `CS_EXT_RISE && $rose(pin_sync_r) |-> timer_tick)
        else $error("rising pin edge gave no tick");
endmodule

// file: hdl/compare_channel.sv
`include "timer_regs.svh"

module compare_channel #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input timer_pkg::chan_evt_type evt,
    input wire logic [1:0] compare_output_mode,
    input wire logic cpu_wr,
    input wire logic [WIDTH-1:0] cpu_data,
    output logic [WIDTH-1:0] compare_active,
    output logic [WIDTH-1:0] compare_buf,
    output logic wave_out,
    output logic wave_oe
);
    import timer_pkg::*;

    logic hit;

    // Buffer takes every CPU write; active copy follows it at once unless buffered
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_buf <= `RST_BYTE;
            compare_active <= `RST_BYTE;
        end else begin
            if (cpu_wr) begin
                compare_buf <= cpu_data;
            end
            if (cpu_wr && !evt.pwm) begin
                compare_active <= cpu_data;
            end else if (evt.pwm && evt.reload) begin
                compare_active <= compare_buf;
            end
        end
    end

    assign hit = evt.force_hit | (evt.tick & evt.match);
    assign wave_oe = |compare_output_mode;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wave_out <= 1'b0;
        end else if (!evt.pwm) begin
            if (hit) begin
                unique case (compare_output_mode)
                    2'h0: wave_out <= wave_out;
                    2'h1: wave_out <= ~wave_out;
                    2'h2: wave_out <= 1'b0;
                    2'h3: wave_out <= 1'b1;
                endcase
            end
        end else if (evt.tick && compare_output_mode[1]) begin
            if (evt.match) begin
                wave_out <= compare_output_mode[0] ^ (evt.phase_correct & evt.counting_down);
            end else if (!evt.phase_correct && evt.at_top) begin
                wave_out <= ~compare_output_mode[0];
            end
        end
    end

    chk_direct_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        cpu_wr && !evt.pwm |=> compare_active == $past(cpu_data))
        else $error("unbuffered write did not reach compare");
    chk_buffer_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.pwm && !evt.reload |=> $stable(compare_active))
        else $error("buffered compare changed off top");
    chk_force_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !evt.pwm && evt.force_hit && compare_output_mode == 2'h1 |=> wave_out != $past(wave_out))
        else $error("force strobe did not toggle output");
endmodule

// file: hdl/timer_counter.sv
// Overview of operation
// - Count and both compare values are 8-bit registers.
// - Every interrupt request is a flag, each gated by its own mask bit.
// - Tick comes from prescaler taps or external pin, with selectable edge.
// - Clock select zero delivers no ticks; counter stays stopped.
// - Count 0x00 is bottom; phase correct mode flags overflow on a tick there.
// - Count 0xFF is the maximum of the 8-bit counter.
// - Top is 0xFF or compare A value, chosen by waveform mode.
// - Each tick clears, increments or decrements the counter by mode.
// - CPU may read and write the count at any time.
// - CPU count write beats a simultaneous hardware clear or step.
// - Waveform mode: two low bits in control A, high bit in control B.
// - Overflow flag sets where the mode says and can request interrupt.
// - Counter is compared with both compare values every cycle.
// - A match sets that channel's compare flag on the next tick.
// - A serviced, unmasked compare interrupt clears its own flag.
// - Writing one clears a flag; writing zero leaves it.
// - Outputs formed from match, waveform mode and output mode, with top/bottom.
// - Compare values double buffered in PWM modes only.
// - Buffered compare value loads into active register only at top.
// - CPU compare access goes to buffer when buffered, else directly.
// - Mode 0 counts up, wraps 0xFF to 0, overflow at zero.
// - Mode 2 clears the counter on a compare A match.
// - A count write blocks all compare matches for the next tick.
// - Non-PWM force strobe acts as a match without flag or clear.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`include "timer_regs.svh"

module timer_counter #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] prescale_taps,
    input wire logic external_count_pin,
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq_req,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_oe_a,
    output logic wave_oe_b
);
    import timer_pkg::*;

    logic [7:0] timer_control_a_r;
    logic [3:0] timer_control_b_r;
    logic [WIDTH-1:0] timer_count_r;
    logic [WIDTH-1:0] count_nxt;
    logic [2:0] timer_flag_register_r;
    logic [2:0] timer_mask_register_r;
    logic block_r;
    logic down_r;
    logic down_nxt;
    logic ack_r;
    logic [7:0] rdat_r;
    logic [7:0] rdat_nxt;

    logic [7:0] adr;
    logic access;
    logic wr;
    logic count_wr;
    logic timer_tick;
    logic [2:0] waveform_mode_field;
    logic pwm;
    logic phase_correct;
    logic top_from_a;
    logic [WIDTH-1:0] top_value;
    logic at_top;
    logic at_bottom;
    logic step_ok;
    logic ovf_set;
    logic [1:0] cmp_set;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [1:0] eq;
    logic [1:0] match;
    logic [1:0] cmp_wr;
    logic [1:0] force_hit;
    logic [1:0] wave;
    logic [1:0] oe;
    logic [WIDTH-1:0] active [2];
    logic [WIDTH-1:0] buffered [2];

    // Wishbone slave: one wait state, ack pulses for a single cycle
    assign adr = {wb_adr_i[7:2], 2'b00};
    assign access = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = access & wb_we_i & wb_sel_i[0];
    assign count_wr = wr & (adr == `OFS_COUNT);
    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, rdat_r};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    always_comb begin
        unique case (adr)
            `OFS_CTRL_A: rdat_nxt = timer_control_a_r;
            `OFS_CTRL_B: rdat_nxt = {4'h0, timer_control_b_r};
            `OFS_COUNT: rdat_nxt = timer_count_r;
            `OFS_CMP_A: rdat_nxt = buffered[0];
            `OFS_CMP_B: rdat_nxt = buffered[1];
            `OFS_FLAGS: rdat_nxt = {5'h00, timer_flag_register_r};
            `OFS_MASK: rdat_nxt = {5'h00, timer_mask_register_r};
            default: rdat_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdat_r <= 8'h00;
        end else if (access) begin
            rdat_r <= rdat_nxt;
        end
    end

    // Control registers; force strobes are not stored and read back as zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_control_a_r <= `RST_BYTE;
            timer_control_b_r <= 4'h0;
            timer_mask_register_r <= `RST_FLAGS;
        end else if (wr) begin
            if (adr == `OFS_CTRL_A) begin
                timer_control_a_r <= wb_dat_i[7:0];
            end
            if (adr == `OFS_CTRL_B) begin
                timer_control_b_r <= wb_dat_i[3:0];
            end
            if (adr == `OFS_MASK) begin
                timer_mask_register_r <= wb_dat_i[2:0];
            end
        end
    end

    assign waveform_mode_field = {timer_control_b_r[`CB_WGM2], timer_control_a_r[`CA_WGM_LO]};
    assign pwm = waveform_mode_field[0];
    assign phase_correct = waveform_mode_field[0] & ~waveform_mode_field[1];
    assign top_from_a = (waveform_mode_field == `WGM_CTC)
                        | (waveform_mode_field[2] & waveform_mode_field[0]);
    assign top_value = top_from_a ? active[0] : `VAL_MAX;
    assign at_top = timer_count_r == top_value;
    assign at_bottom = timer_count_r == `VAL_BOTTOM;
    assign step_ok = timer_tick & ~count_wr;

    tick_select u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clock_select_field(timer_control_b_r[`CB_CS]),
        .prescale_taps(prescale_taps),
        .external_count_pin(external_count_pin),
        .timer_tick(timer_tick)
    );

    // Counter sequencing per waveform mode
    always_comb begin
        count_nxt = timer_count_r;
        down_nxt = down_r;
        if (timer_tick) begin
            if (phase_correct) begin
                if (at_top) begin
                    down_nxt = 1'b1;
                end else if (at_bottom) begin
                    down_nxt = 1'b0;
                end
                count_nxt = down_nxt ? timer_count_r - 8'h01 : timer_count_r + 8'h01;
            end else if ((waveform_mode_field == `WGM_CTC && match[0]) || (pwm && at_top)) begin
                count_nxt = `VAL_BOTTOM;
            end else begin
                count_nxt = timer_count_r + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_count_r <= `RST_BYTE;
            down_r <= 1'b0;
        end else if (count_wr) begin
            timer_count_r <= wb_dat_i[7:0];
        end else begin
            timer_count_r <= count_nxt;
            down_r <= down_nxt;
        end
    end

    // A count write blocks matches until the following tick has passed
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            block_r <= 1'b0;
        end else if (count_wr) begin
            block_r <= 1'b1;
        end else if (timer_tick) begin
            block_r <= 1'b0;
        end
    end

    // Flags: hardware set wins over a clear in the same cycle
    assign ovf_set = step_ok & (pwm ? (phase_correct ? at_bottom : at_top)
                               : timer_count_r == `VAL_MAX);
    assign cmp_set = {2{step_ok}} & match;
    assign flag_set = {cmp_set, ovf_set};
    assign flag_clr = (wr && adr == `OFS_FLAGS ? wb_dat_i[2:0] : 3'h0)
                      | (irq_ack & timer_mask_register_r);
    assign irq_req = timer_flag_register_r & timer_mask_register_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_flag_register_r <= `RST_FLAGS;
        end else begin
            timer_flag_register_r <= (timer_flag_register_r & ~flag_clr) | flag_set;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_chan
            localparam int FOC_BIT = (i == 0) ? `CB_FOC_A : `CB_FOC_B;
            chan_evt_type evt;
            logic [7:0] cmp_ofs;

            assign cmp_ofs = (i == 0) ? `OFS_CMP_A : `OFS_CMP_B;
            assign eq[i] = timer_count_r == active[i];
            assign match[i] = eq[i] & ~block_r;
            assign cmp_wr[i] = wr & (adr == cmp_ofs);
            assign force_hit[i] = wr & (adr == `OFS_CTRL_B) & wb_dat_i[FOC_BIT] & ~pwm;
            assign evt.tick = step_ok;
            assign evt.match = match[i];
            assign evt.force_hit = force_hit[i];
            assign evt.at_top = at_top;
            assign evt.counting_down = down_r;
            assign evt.pwm = pwm;
            assign evt.phase_correct = phase_correct;
            assign evt.reload = step_ok & at_top;

            compare_channel #(.WIDTH(WIDTH)) u_chan (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .evt(evt),
                .compare_output_mode(timer_control_a_r[7-2*i -: 2]),
                .cpu_wr(cmp_wr[i]),
                .cpu_data(wb_dat_i[WIDTH-1:0]),
                .compare_active(active[i]),
                .compare_buf(buffered[i]),
                .wave_out(wave[i]),
                .wave_oe(oe[i])
            );
        end
    endgenerate

    assign wave_out_a = wave[0];
    assign wave_out_b = wave[1];
    assign wave_oe_a = oe[0];
    assign wave_oe_b = oe[1];

    // Rule checks on counter, flags and bus
    chk_write_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        count_wr |=> timer_count_r == $past(wb_dat_i[7:0]))
        else $error("count write lost to hardware update");

    chk_stop_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_control_b_r[`CB_CS] == `CS_STOP && !count_wr |=> $stable(timer_count_r))
        else $error("stopped counter moved");

    chk_normal_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        waveform_mode_field == `WGM_NORMAL && step_ok && timer_count_r == 8'hff
        |=> timer_count_r == 8'h00 && timer_flag_register_r[`FL_OVF])
        else $error("normal wrap or overflow flag wrong");

    chk_ctc_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        waveform_mode_field == `WGM_CTC && step_ok && match[0] |=> timer_count_r == 8'h00)
        else $error("clear on compare A missing");

    chk_match_blocked: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(count_wr) && !count_wr |-> cmp_set == 2'h0)
        else $error("match not blocked after count write");

    chk_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmp_set[0] |=> timer_flag_register_r[`FL_CMP_A])
        else $error("compare flag set was lost");

    chk_w1c_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && adr == `OFS_FLAGS && wb_dat_i[`FL_OVF] && !ovf_set
        |=> !timer_flag_register_r[`FL_OVF])
        else $error("write one did not clear overflow");

    chk_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        access |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");

    chk_ovf_bottom: assert property (@(posedge core_clk) disable iff (!rst_n)
        phase_correct && step_ok && at_bottom |=> timer_flag_register_r[`FL_OVF])
        else $error("phase correct overflow missing at bottom");

    chk_fast_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        pwm && !phase_correct && step_ok && at_top |=> timer_count_r == `VAL_BOTTOM)
        else $error("fast pwm did not wrap at top");

    chk_pc_turn_down: assert property (@(posedge core_clk) disable iff (!rst_n)
        phase_correct && step_ok && at_top && !at_bottom
        |=> timer_count_r == $past(timer_count_r) - 8'h01)
        else $error("phase correct did not turn down at top");

    chk_mode_low_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && adr == `OFS_CTRL_A |=> waveform_mode_field[1:0] == $past(wb_dat_i[1:0]))
        else $error("waveform mode low bits not stored");

    chk_mode_high_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && adr == `OFS_CTRL_B |=> waveform_mode_field[2] == $past(wb_dat_i[`CB_WGM2]))
        else $error("waveform mode high bit not stored");

    chk_serve_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq_ack[`FL_CMP_A] && timer_mask_register_r[`FL_CMP_A] && !cmp_set[0]
        |=> !timer_flag_register_r[`FL_CMP_A])
        else $error("serviced compare flag not cleared");

    chk_zero_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && adr == `OFS_FLAGS && !wb_dat_i[`FL_CMP_A] && !irq_ack[`FL_CMP_A]
        && timer_flag_register_r[`FL_CMP_A] |=> timer_flag_register_r[`FL_CMP_A])
        else $error("zero write cleared a flag");

    chk_flag_needs_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
        !step_ok |=> !$rose(timer_flag_register_r[`FL_CMP_A]))
        else $error("compare flag set without a tick");

    // Main scenarios
    cov_ctc_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
        waveform_mode_field == `WGM_CTC && step_ok && match[0]);

    cov_pc_turn: cover property (@(posedge core_clk) disable iff (!rst_n)
        phase_correct && step_ok && at_top ##[1:600] ovf_set);

    cov_force: cover property (@(posedge core_clk) disable iff (!rst_n) force_hit[1]);

    cov_div1_tick: cover property (@(posedge core_clk) disable iff (!rst_n)
        timer_control_b_r[`CB_CS] == `CS_DIV1 && step_ok);

    cov_pc_down_match: cover property (@(posedge core_clk) disable iff (!rst_n)
        phase_correct && step_ok && match[0] && down_r);
endmodule

// file: test/timer_counter_tb.sv
`include "timer_regs.svh"

module timer_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk;
    logic rst_n;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] prescale_taps;
    logic external_count_pin;
    logic [2:0] irq_ack;
    logic [2:0] irq_req;
    logic wave_out_a;
    logic wave_out_b;
    logic wave_oe_a;
    logic wave_oe_b;
    int n_errors = 0;
    int comparisons = 0;

    timer_counter #(.WIDTH(8)) i_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .prescale_taps(prescale_taps),
        .external_count_pin(external_count_pin),
        .irq_ack(irq_ack),
        .irq_req(irq_req),
        .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b),
        .wave_oe_a(wave_oe_a),
        .wave_oe_b(wave_oe_b)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // One classic cycle; ends one idle cycle after the ack edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, wd};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            $display("unexpected missing ack at address %h", adr);
        end
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, adr, d, r);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input string what);
        logic [7:0] r;
        bus(1'b0, adr, 8'h00, r);
        check(what, r, exp);
    endtask

    task automatic tick(input int idx);
        prescale_taps[idx] <= 1'b1;
        @(posedge core_clk);
        prescale_taps <= 4'h0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic pin(input logic v);
        external_count_pin <= v;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic serve(input int idx);
        irq_ack[idx] <= 1'b1;
        @(posedge core_clk);
        irq_ack <= 3'h0;
        @(posedge core_clk);
    endtask

    initial begin
        repeat (10000) @(posedge core_clk);
        n_errors++;
        $display("unexpected timeout");
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        prescale_taps = 4'h0;
        external_count_pin = 1'b0;
        irq_ack = 3'h0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);

        for (int a = 0; a < 8; a++) begin
            rd(8'(a * 4), 8'h00, "reset register");
        end
        check("irq_req", {5'h00, irq_req}, 8'h00);
        check("wave outputs", {4'h0, wave_out_a, wave_out_b, wave_oe_a, wave_oe_b}, 8'h00);
        $display("test reset done");

        wr(`OFS_COUNT, 8'ha5);
        rd(`OFS_COUNT, 8'ha5, "count readback");
        pin(1'b1);
        pin(1'b0);
        rd(`OFS_COUNT, 8'ha5, "stopped count");
        wr(`OFS_CTRL_B, 8'h01);
        wr(`OFS_CTRL_B, 8'h00);
        rd(`OFS_COUNT, 8'ha8, "every cycle count");
        $display("test stopped done");

        for (int cs = 2; cs <= 5; cs++) begin
            wr(`OFS_CTRL_B, 8'(cs));
            wr(`OFS_COUNT, 8'h10);
            tick(cs - 2);
            rd(`OFS_COUNT, 8'h11, "tap count");
            tick((cs - 1) % 4);
            rd(`OFS_COUNT, 8'h11, "other tap");
        end
        $display("test taps done");

        wr(`OFS_CTRL_B, 8'h07);
        wr(`OFS_COUNT, 8'h00);
        pin(1'b1);
        rd(`OFS_COUNT, 8'h01, "rising edge count");
        pin(1'b0);
        rd(`OFS_COUNT, 8'h01, "falling ignored");
        wr(`OFS_CTRL_B, 8'h06);
        pin(1'b1);
        pin(1'b0);
        rd(`OFS_COUNT, 8'h02, "falling edge count");
        $display("test pin done");

        wr(`OFS_CTRL_B, 8'h02);
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_COUNT, 8'hfe);
        tick(0);
        rd(`OFS_FLAGS, 8'h00, "no overflow at max");
        tick(0);
        rd(`OFS_COUNT, 8'h00, "wrapped count");
        rd(`OFS_FLAGS, 8'h01, "overflow flag");
        check("masked irq", {5'h00, irq_req}, 8'h00);
        wr(`OFS_MASK, 8'h01);
        check("overflow irq", {5'h00, irq_req}, 8'h01);
        serve(0);
        rd(`OFS_FLAGS, 8'h00, "overflow served");
        $display("test overflow done");

        wr(`OFS_CMP_A, 8'h05);
        rd(`OFS_CMP_A, 8'h05, "compare a");
        wr(`OFS_COUNT, 8'h04);
        tick(0);
        rd(`OFS_FLAGS, 8'h00, "flag before tick");
        tick(0);
        rd(`OFS_FLAGS, 8'h02, "compare a flag");
        wr(`OFS_MASK, 8'h03);
        check("compare irq", {5'h00, irq_req}, 8'h02);
        wr(`OFS_FLAGS, 8'h00);
        rd(`OFS_FLAGS, 8'h02, "zero write keeps");
        wr(`OFS_FLAGS, 8'h02);
        rd(`OFS_FLAGS, 8'h00, "one write clears");
        wr(`OFS_COUNT, 8'h05);
        tick(0);
        rd(`OFS_FLAGS, 8'h00, "match blocked");
        wr(`OFS_COUNT, 8'h04);
        tick(0);
        tick(0);
        serve(1);
        rd(`OFS_FLAGS, 8'h00, "compare served");
        $display("test compare done");

        wr(`OFS_CTRL_A, 8'h02);
        wr(`OFS_CMP_A, 8'h03);
        wr(`OFS_COUNT, 8'h02);
        tick(0);
        rd(`OFS_COUNT, 8'h03, "count to top");
        tick(0);
        rd(`OFS_COUNT, 8'h00, "clear on match");
        $display("test clear on match done");

        wr(`OFS_CTRL_A, 8'h00);
        wr(`OFS_CMP_B, 8'h10);
        wr(`OFS_CTRL_A, 8'h03);
        wr(`OFS_CMP_B, 8'h20);
        rd(`OFS_CMP_B, 8'h20, "buffer read");
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_COUNT, 8'h0f);
        tick(0);
        tick(0);
        rd(`OFS_FLAGS, 8'h04, "old active value");
        wr(`OFS_COUNT, 8'hfe);
        tick(0);
        tick(0);
        rd(`OFS_COUNT, 8'h00, "fast wrap at top");
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_COUNT, 8'h1f);
        tick(0);
        tick(0);
        rd(`OFS_FLAGS, 8'h04, "reloaded at top");
        $display("test buffering done");

        wr(`OFS_CTRL_B, 8'h00);
        wr(`OFS_CTRL_A, 8'h40);
        wr(`OFS_FLAGS, 8'h07);
        repeat (2) @(posedge core_clk);
        check("oe a", {7'h00, wave_oe_a}, 8'h01);
        check("wave a idle", {7'h00, wave_out_a}, 8'h00);
        wr(`OFS_CTRL_B, 8'h80);
        repeat (2) @(posedge core_clk);
        check("forced toggle", {7'h00, wave_out_a}, 8'h01);
        rd(`OFS_FLAGS, 8'h00, "force sets no flag");
        rd(`OFS_CTRL_B, 8'h00, "strobe reads zero");
        wr(`OFS_CTRL_B, 8'h80);
        repeat (2) @(posedge core_clk);
        check("forced toggle back", {7'h00, wave_out_a}, 8'h00);
        wr(`OFS_CTRL_A, 8'h10);
        wr(`OFS_CTRL_B, 8'h40);
        repeat (2) @(posedge core_clk);
        check("forced toggle b", {6'h00, wave_out_b, wave_oe_b}, 8'h03);
        $display("test force done");

        wr(`OFS_CTRL_A, 8'h81);
        wr(`OFS_CTRL_B, 8'h02);
        wr(`OFS_COUNT, 8'hfe);
        repeat (2) tick(0);
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_COUNT, 8'h05);
        repeat (3) tick(0);
        check("down match sets", {7'h00, wave_out_a}, 8'h01);
        repeat (3) tick(0);
        rd(`OFS_FLAGS, 8'h03, "overflow at bottom");
        rd(`OFS_COUNT, 8'h01, "turned up at bottom");
        repeat (3) tick(0);
        check("up match clears", {7'h00, wave_out_a}, 8'h00);
        $display("test phase correct done");

        test_done();
    end
endmodule
